/* File: logic/tcz_pkg.sv */
// Shared constants and types for the dual timer/counter block.
package tcz_pkg;

    // ----------------------------------------------------------------
    // Machine cycle timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PER_MACHINE = 12;             // Core clocks in one machine cycle.
    localparam logic [3:0]  PHASE_LAST      = 4'(CLK_PER_MACHINE - 1); // Last phase index of a cycle.
    localparam logic [3:0]  SAMPLE_PHASE    = 4'h9;           // Pin sample point, state 5 phase 2.
    localparam logic [3:0]  UPDATE_PHASE    = 4'h4;           // Count update point, state 3 phase 1.
    localparam logic [3:0]  UPDATE_STROBE   = 4'(UPDATE_PHASE - 4'h1); // Strobe one clock early, tick is registered.

    // ----------------------------------------------------------------
    // Register addresses on the special-function bus
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;        // Control register, bit addressable.
    localparam logic [7:0] ADDR_TIMER_MODE    = 8'h89;        // Mode register, byte access only.
    localparam logic [7:0] ADDR_ZERO_LOW      = 8'h8A;        // Counter zero low byte.
    localparam logic [7:0] ADDR_ONE_LOW       = 8'h8B;        // Counter one low byte.
    localparam logic [7:0] ADDR_ZERO_HIGH     = 8'h8C;        // Counter zero high byte.
    localparam logic [7:0] ADDR_ONE_HIGH      = 8'h8D;        // Counter one high byte.

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;       // Control register after reset.
    localparam logic [7:0] TIMER_MODE_RESET    = 8'h00;       // Mode register after reset.
    localparam logic [7:0] COUNT_BYTE_RESET    = 8'h00;       // Count bytes after reset.

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int unsigned CTL_FLAG_ONE  = 7;                // Overflow flag, counter one.
    localparam int unsigned CTL_RUN_ONE   = 6;                // Run bit, counter one.
    localparam int unsigned CTL_FLAG_ZERO = 5;                // Overflow flag, counter zero.
    localparam int unsigned CTL_RUN_ZERO  = 4;                // Run bit, counter zero.
    localparam int unsigned MODE_GATE_ONE = 7;                // Gate enable, counter one.
    localparam int unsigned MODE_SRC_ONE  = 6;                // Event source select, counter one.
    localparam int unsigned MODE_SEL_ONE  = 4;                // Mode field base, counter one.
    localparam int unsigned MODE_GATE_ZERO = 3;               // Gate enable, counter zero.
    localparam int unsigned MODE_SRC_ZERO = 2;                // Event source select, counter zero.
    localparam int unsigned MODE_SEL_ZERO = 0;                // Mode field base, counter zero.
    localparam logic [4:0]  PRESCALE_TOP  = 5'h1F;            // Prescaler terminal count.

    // Operating mode codes, high select bit then low select bit.
    typedef enum logic [1:0] {
        TCZ_MODE_PRESCALE = 2'b00,
        TCZ_MODE_WIDE     = 2'b01,
        TCZ_MODE_RELOAD   = 2'b10,
        TCZ_MODE_SPLIT    = 2'b11
    } tcz_mode_e;

endpackage

/* File: logic/tcz_tick_if.sv */
// Carrier between the main block and one event sampling unit.
`timescale 1ns/1ps
`default_nettype none
interface tcz_tick_if;
    logic sample_stb;  // One-clock strobe at the pin sample phase.
    logic update_stb;  // One-clock strobe one clock before the update phase.
    logic event_sel;   // High selects the external pin, low counts machine cycles.
    logic event_pin;   // External count pin level.
    logic tick;        // One-clock count pulse, lands on the update phase.

    modport ctrl (output sample_stb, output update_stb, output event_sel, output event_pin, input tick);
    modport unit (input sample_stb, input update_stb, input event_sel, input event_pin, output tick);
endinterface
`default_nettype wire

/* File: logic/tcz_event_unit.sv */
// Count source for one timer: machine cycles or falling edges on a pin.
`timescale 1ns/1ps
`default_nettype none
module tcz_event_unit (
    input  wire logic    sys_clk,
    input  wire logic    sys_rst,
    tcz_tick_if.unit     link
);
    import tcz_pkg::*;

    // ----------------------------------------------------------------
    // Sample history
    // ----------------------------------------------------------------
    logic last_sample;  // Pin level taken at the previous sample phase.
    logic fall_pending; // A high-then-low pair was seen, waiting for the update.

    // The pin is looked at only once per machine cycle, so a level shorter
    // than one machine cycle may be missed; the source must hold each level.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            last_sample <= 1'b0;
        end else if (link.sample_stb) begin
            last_sample <= link.event_pin; // R3
        end
    end

    // A detected fall is held until the next update strobe, which gives
    // the two machine cycle latency and caps the event rate.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            fall_pending <= 1'b0;
        end else if (link.sample_stb && last_sample && !link.event_pin) begin
            fall_pending <= 1'b1; // R3 R5
        end else if (link.update_stb) begin
            fall_pending <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Count pulse
    // ----------------------------------------------------------------
    // Registered, so it lands exactly on the update phase.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            link.tick <= 1'b0;
        end else begin
            link.tick <= link.update_stb && (link.event_sel ? fall_pending : 1'b1); // R2 R4
        end
    end

endmodule
`default_nettype wire

/* File: logic/tcz_timer_pair.sv */
// Two timer/counters with their mode and control registers.
//
// Behaviour
// R1 - Two counters, each high and low bytes
// R2 - Timer function counts one per machine cycle
// R3 - Pin sampled each cycle; high-then-low counts
// R4 - Counted edge appears at next update phase
// R5 - Two-cycle edge detection limits event rate
// R6 - Source holds each level one machine cycle
// R7 - Counter one gate uses its gate pin
// R8 - Mode bit 6 selects counter one source
// R9 - Mode 00: 8-bit with 5-bit prescaler
// R10 - Mode 01: 16-bit cascaded counter
// R11 - Mode 10: low byte reloads from high
// R12 - Counter zero gate uses its gate pin
// R13 - Mode bit 2 selects counter zero source
// R14 - Mode 11: split counter zero bytes
// R15 - Mode register at 89H, resets to 00H
// R16 - Control register at 88H, bit addressable
// R17 - Overflow sets flag; vector acknowledge clears
// R18 - Run bits start and stop counters
// R19 - Prescaled mode ignores upper low bits
// R20 - Count byte writes beat counting

`timescale 1ns/1ps
`default_nettype none
module tcz_timer_pair (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // Special-function bus.
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic [7:0]  sfr_wdata,
    input  wire logic        sfr_rd,
    output var  logic [7:0]  sfr_rdata,
    input  wire logic        sfr_bit_wr,
    input  wire logic [2:0]  sfr_bit_sel,
    input  wire logic        sfr_bit_val,
    // Interrupt vector acknowledges.
    input  wire logic        vector_ack_zero,
    input  wire logic        vector_ack_one,
    // External pins.
    input  wire logic        gate_pin_counter_zero,
    input  wire logic        gate_pin_counter_one,
    input  wire logic        event_pin_counter_zero,
    input  wire logic        event_pin_counter_one,
    // Overflow flags towards the interrupt controller.
    output var  logic        overflow_flag_counter_zero,
    output var  logic        overflow_flag_counter_one
);
    import tcz_pkg::*;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [7:0] timer_control;          // Flags, run bits and four plain bits.
    logic [7:0] timer_mode;             // Gate, source and mode per counter.
    logic [7:0] counter_zero_low_byte;  // Counter zero low byte.
    logic [7:0] counter_zero_high_byte; // Counter zero high byte.
    logic [7:0] counter_one_low_byte;   // Counter one low byte.
    logic [7:0] counter_one_high_byte;  // Counter one high byte.

    logic [3:0] phase;                  // Position inside the machine cycle.
    logic       machine_tick;           // Plain machine cycle pulse on the update phase.

    tcz_tick_if link_zero ();           // Count source of counter zero.
    tcz_tick_if link_one ();            // Count source of counter one.

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // One step of a counter in modes 00 to 10; returns overflow, high, low.
    function automatic logic [16:0] step_counter(input tcz_mode_e mode,
                                                 input logic [7:0] low,
                                                 input logic [7:0] high);
        logic [8:0]  low_sum;
        logic [8:0]  high_sum;
        logic [16:0] result;

        low_sum  = {1'b0, low} + 9'h001;
        high_sum = {1'b0, high} + 9'h001;
        result   = {1'b0, high, low};

        unique case (mode)
            TCZ_MODE_PRESCALE: begin
                // Upper three low bits are left alone; software must ignore them.
                if (low[4:0] == PRESCALE_TOP) begin
                    result = {high_sum[8], high_sum[7:0], low[7:5], 5'h00}; // R9 R19
                end else begin
                    result = {1'b0, high, low[7:5], 5'(low[4:0] + 5'h01)}; // R9
                end
            end
            TCZ_MODE_WIDE: begin
                if (low_sum[8]) begin
                    result = {high_sum[8], high_sum[7:0], 8'h00}; // R10
                end else begin
                    result = {1'b0, high, low_sum[7:0]}; // R10
                end
            end
            TCZ_MODE_RELOAD: begin
                // Reload leaves the high byte untouched.
                result = low_sum[8] ? {1'b1, high, high} : {1'b0, high, low_sum[7:0]}; // R11
            end
            TCZ_MODE_SPLIT: begin
                result = {1'b0, high, low}; // Handled by the caller.
            end
        endcase
        return result;
    endfunction

    // ----------------------------------------------------------------
    // Machine cycle sequencer
    // ----------------------------------------------------------------
    // Twelve core clocks make one machine cycle.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            phase <= 4'h0;
        end else begin
            phase <= (phase == PHASE_LAST) ? 4'h0 : phase + 4'h1; // R2
        end
    end

    // Pure timer pulse for the split-mode high byte, aligned with the units.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            machine_tick <= 1'b0;
        end else begin
            machine_tick <= (phase == UPDATE_STROBE);
        end
    end

    // ----------------------------------------------------------------
    // Count sources
    // ----------------------------------------------------------------
    assign link_zero.sample_stb = (phase == SAMPLE_PHASE);
    assign link_zero.update_stb = (phase == UPDATE_STROBE);
    assign link_zero.event_sel  = timer_mode[MODE_SRC_ZERO]; // R13
    assign link_zero.event_pin  = event_pin_counter_zero;
    assign link_one.sample_stb  = (phase == SAMPLE_PHASE);
    assign link_one.update_stb  = (phase == UPDATE_STROBE);
    assign link_one.event_sel   = timer_mode[MODE_SRC_ONE]; // R8
    assign link_one.event_pin   = event_pin_counter_one;

    tcz_event_unit unit_zero (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .link    (link_zero.unit)
    );

    tcz_event_unit unit_one (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .link    (link_one.unit)
    );

    // ----------------------------------------------------------------
    // Run qualification and next count values
    // ----------------------------------------------------------------
    tcz_mode_e   mode_zero;    // Mode of counter zero.
    tcz_mode_e   mode_one;     // Mode of counter one.
    logic        run_zero;     // Counter zero enabled by run bit and gate.
    logic        run_one;      // Counter one enabled by run bit and gate.
    logic [16:0] step_zero;    // Stepped value of counter zero.
    logic [16:0] step_one;     // Stepped value of counter one.
    logic [8:0]  split_low;    // Split-mode low byte plus one.
    logic [8:0]  split_high;   // Split-mode high byte plus one.

    // Next values of the four count bytes.
    logic [7:0]  next_zero_low;
    logic [7:0]  next_zero_high;
    logic [7:0]  next_one_low;
    logic [7:0]  next_one_high;

    logic        set_flag_zero; // Overflow event for flag zero.
    logic        set_flag_one;  // Overflow event for flag one.

    assign mode_zero = tcz_mode_e'(timer_mode[MODE_SEL_ZERO +: 2]);
    assign mode_one  = tcz_mode_e'(timer_mode[MODE_SEL_ONE +: 2]);

    // The gate pin only matters when the gate bit is set.
    assign run_zero  = timer_control[CTL_RUN_ZERO]
                       && (!timer_mode[MODE_GATE_ZERO] || gate_pin_counter_zero); // R12 R18
    assign run_one   = timer_control[CTL_RUN_ONE]
                       && (!timer_mode[MODE_GATE_ONE] || gate_pin_counter_one); // R7 R18

    assign step_zero  = step_counter(mode_zero, counter_zero_low_byte, counter_zero_high_byte);
    assign step_one   = step_counter(mode_one, counter_one_low_byte, counter_one_high_byte);

    assign split_low  = {1'b0, counter_zero_low_byte} + 9'h001;
    assign split_high = {1'b0, counter_zero_high_byte} + 9'h001;

    // Pick the next count values and overflow events for both counters.
    always_comb begin
        next_zero_low  = counter_zero_low_byte;
        next_zero_high = counter_zero_high_byte;
        next_one_low   = counter_one_low_byte;
        next_one_high  = counter_one_high_byte;
        set_flag_zero  = 1'b0;
        set_flag_one   = 1'b0;

        if (mode_zero == TCZ_MODE_SPLIT) begin
            // Low byte keeps the counter zero controls.
            if (link_zero.tick && run_zero) begin
                next_zero_low = split_low[7:0]; // R14
                set_flag_zero = split_low[8]; // R14 R17
            end

            // High byte counts machine cycles under the counter one run bit only.
            if (machine_tick && timer_control[CTL_RUN_ONE]) begin
                next_zero_high = split_high[7:0]; // R14
                set_flag_one   = split_high[8]; // R14 R17
            end
        end else if (link_zero.tick && run_zero) begin
            next_zero_high = step_zero[15:8];
            next_zero_low  = step_zero[7:0];
            set_flag_zero  = step_zero[16]; // R17
        end

        // Mode 11 stops counter one; it can still run while counter zero
        // is split, but then its flag belongs to the counter zero high byte.
        if (link_one.tick && run_one && mode_one != TCZ_MODE_SPLIT) begin
            next_one_high = step_one[15:8];
            next_one_low  = step_one[7:0];
            if (mode_zero != TCZ_MODE_SPLIT) begin
                set_flag_one = step_one[16]; // R17
            end
        end
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    logic wr_control; // Byte write to the control register.
    logic wr_mode;    // Byte write to the mode register.
    logic bit_wr_ok;  // Bit write that lands on the control register.

    assign wr_control = sfr_wr && (sfr_addr == ADDR_TIMER_CONTROL); // R16
    assign wr_mode    = sfr_wr && (sfr_addr == ADDR_TIMER_MODE); // R15

    // Bit writes reach the control register only; the mode register is not bit addressable.
    assign bit_wr_ok  = sfr_bit_wr && (sfr_addr == ADDR_TIMER_CONTROL); // R16 R15

    // Mode register: byte writes only.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            timer_mode <= TIMER_MODE_RESET; // R15
        end else if (wr_mode) begin
            timer_mode <= sfr_wdata; // R15
        end
    end

    // Control register: software writes, then acknowledges and hardware flag
    // events. A flag set in the same cycle as any clear survives.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            timer_control <= TIMER_CONTROL_RESET; // R16
        end else begin
            logic [7:0] value;
            value = timer_control;

            if (wr_control) begin
                value = sfr_wdata; // R18
            end else if (bit_wr_ok) begin
                value[sfr_bit_sel] = sfr_bit_val; // R16 R18
            end

            if (vector_ack_zero) begin
                value[CTL_FLAG_ZERO] = 1'b0; // R17
            end
            if (vector_ack_one) begin
                value[CTL_FLAG_ONE] = 1'b0; // R17
            end

            if (set_flag_zero) begin
                value[CTL_FLAG_ZERO] = 1'b1; // R17
            end
            if (set_flag_one) begin
                value[CTL_FLAG_ONE] = 1'b1; // R17
            end

            timer_control <= value;
        end
    end

    // Counter zero bytes: a software write beats a count or reload.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            counter_zero_low_byte  <= COUNT_BYTE_RESET;
            counter_zero_high_byte <= COUNT_BYTE_RESET;
        end else begin
            counter_zero_low_byte  <= (sfr_wr && sfr_addr == ADDR_ZERO_LOW)  ? sfr_wdata : next_zero_low; // R20 R1
            counter_zero_high_byte <= (sfr_wr && sfr_addr == ADDR_ZERO_HIGH) ? sfr_wdata : next_zero_high; // R20 R1
        end
    end

    // Counter one bytes: same precedence as counter zero.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            counter_one_low_byte  <= COUNT_BYTE_RESET;
            counter_one_high_byte <= COUNT_BYTE_RESET;
        end else begin
            counter_one_low_byte  <= (sfr_wr && sfr_addr == ADDR_ONE_LOW)  ? sfr_wdata : next_one_low; // R20 R1
            counter_one_high_byte <= (sfr_wr && sfr_addr == ADDR_ONE_HIGH) ? sfr_wdata : next_one_high; // R20 R1
        end
    end

    // ----------------------------------------------------------------
    // Read path and flag outputs
    // ----------------------------------------------------------------
    // Read data is registered: it appears the clock after the read strobe
    // and holds until the next read. Unmapped addresses read as zero.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            unique case (sfr_addr)
                ADDR_TIMER_CONTROL: sfr_rdata <= timer_control;
                ADDR_TIMER_MODE:    sfr_rdata <= timer_mode;
                ADDR_ZERO_LOW:      sfr_rdata <= counter_zero_low_byte;
                ADDR_ONE_LOW:       sfr_rdata <= counter_one_low_byte;
                ADDR_ZERO_HIGH:     sfr_rdata <= counter_zero_high_byte;
                ADDR_ONE_HIGH:      sfr_rdata <= counter_one_high_byte;
                default:            sfr_rdata <= 8'h00;
            endcase
        end
    end

    // Flags are copied into output flip-flops, one clock behind the register.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            overflow_flag_counter_zero <= 1'b0;
            overflow_flag_counter_one  <= 1'b0;
        end else begin
            overflow_flag_counter_zero <= timer_control[CTL_FLAG_ZERO]; // R17
            overflow_flag_counter_one  <= timer_control[CTL_FLAG_ONE]; // R17
        end
    end

endmodule
`default_nettype wire

/* File: bench/tcz_pins_model.sv */
// Partner model: the external count and gate pins of both counters.
`timescale 1ns/1ps
`default_nettype none
module tcz_pins_model (
    input  wire logic sys_clk,
    output logic      event_pin_counter_zero,
    output logic      event_pin_counter_one,
    output logic      gate_pin_counter_zero,
    output logic      gate_pin_counter_one
);
    // All pins rest low until a test moves them.
    initial begin
        {event_pin_counter_zero, event_pin_counter_one, gate_pin_counter_zero, gate_pin_counter_one} = 4'h0;
    end
    // Falling edges on both count pins; each level lasts a full machine cycle so it is seen.
    task automatic pulses(input int n);
        repeat (n) begin
            {event_pin_counter_zero, event_pin_counter_one} = 2'b11;
            repeat (12) @(negedge sys_clk);
            {event_pin_counter_zero, event_pin_counter_one} = 2'b00;
            repeat (12) @(negedge sys_clk);
        end
    endtask
    // Gate levels, counter one in the upper bit.
    task automatic gates(input logic [1:0] g);
        {gate_pin_counter_one, gate_pin_counter_zero} = g;
    endtask
endmodule
`default_nettype wire

/* File: bench/tcz_timer_pair_chk.sv */
// Assertions on the register bus and the overflow flags of the timer pair.
`timescale 1ns/1ps
`default_nettype none
module tcz_timer_pair_chk (
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic       sfr_bit_wr,
    input wire logic [2:0] sfr_bit_sel,
    input wire logic       sfr_bit_val,
    input wire logic       vector_ack_zero,
    input wire logic       vector_ack_one,
    input wire logic       overflow_flag_counter_zero,
    input wire logic       overflow_flag_counter_one
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Software access to the control register, which may clear a flag.
    wire logic ctl_sw  = (sfr_wr || sfr_bit_wr) && sfr_addr == 8'h88;
    // Mode and count bytes; hardware changes the count bytes on its own while their counter runs.
    wire logic plain   = sfr_addr >= 8'h89 && sfr_addr <= 8'h8D;
    wire logic rd_only = sfr_rd && !sfr_wr && !sfr_bit_wr;

    reset_clears_a: assert property ($fell(sys_rst) |-> sfr_rdata == 8'h00
        && !overflow_flag_counter_zero && !overflow_flag_counter_one) else $error("state not clear after reset");
    read_holds_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (sfr_rd && !(plain || sfr_addr == 8'h88) |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    write_read_a: assert property (sfr_wr && plain ##2 rd_only && $stable(sfr_addr)
        |=> sfr_rdata == $past(sfr_wdata, 3)) else $error("written byte not read back");
    bit_lands_a: assert property (sfr_bit_wr && !sfr_wr && sfr_addr == 8'h88 && sfr_bit_sel inside {3'd4, 3'd6}
        ##2 rd_only && sfr_addr == 8'h88 |=> sfr_rdata[$past(sfr_bit_sel, 3)] == $past(sfr_bit_val, 3))
        else $error("control bit write not read back");
    bit_ignored_a: assert property (rd_only && sfr_addr == 8'h89 ##2 !sfr_wr && sfr_addr == 8'h89
        ##2 rd_only && sfr_addr == 8'h89 |=> $stable(sfr_rdata)) else $error("mode byte took a bit write");
    flag_zero_clear_a: assert property ($fell(overflow_flag_counter_zero)
        |-> $past(vector_ack_zero, 2) || $past(ctl_sw, 2) || $past(sys_rst)) else $error("flag zero fell alone");
    flag_one_clear_a: assert property ($fell(overflow_flag_counter_one)
        |-> $past(vector_ack_one, 2) || $past(ctl_sw, 2) || $past(sys_rst)) else $error("flag one fell alone");
endmodule
bind tcz_timer_pair tcz_timer_pair_chk u_tcz_timer_pair_chk (.*);
`default_nettype wire

/* File: bench/tcz_timer_pair_tb_top.sv */
// Self-checking bench for the dual timer/counter pair.
`timescale 1ns/1ps
`default_nettype none
module tcz_timer_pair_tb_top;
    logic        sys_clk, sys_rst, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, vector_ack_zero, vector_ack_one;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
    logic [2:0]  sfr_bit_sel;
    logic        overflow_flag_counter_zero, overflow_flag_counter_one;
    logic        event_pin_counter_zero, event_pin_counter_one, gate_pin_counter_zero, gate_pin_counter_one;
    logic [71:0] r;
    int          err_count, n_compared;
    // Row: mode, low address, low, high, gates and run bit, machine cycles, then low, high, control expected.
    localparam logic [71:0] TAB [8] = '{72'h02_8AFE_FE04_02FE_FE20, 72'h01_8AFF_1204_0100_1300,
        72'h00_8AFF_0504_01E0_0600, 72'h03_8A10_FF06_0110_0080, 72'h09_8A00_0004_0300_0000,
        72'h09_8A00_0014_0303_0000, 72'h90_8B00_0006_0200_0000, 72'h90_8B00_0026_0202_0000};

    tcz_timer_pair u_tcz_timer_pair (.*);
    tcz_pins_model u_tcz_pins_model (.*);

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // One bus access; kind 0 writes a byte, 1 reads, 2 writes bit d[2:0] with value d[3].
    task automatic op(input int k, input logic [7:0] a, input logic [7:0] d);
        {sfr_addr, sfr_wdata, sfr_bit_sel, sfr_bit_val} = {a, d, d[2:0], d[3]};
        {sfr_wr, sfr_rd, sfr_bit_wr} = {k == 0, k == 1, k == 2};
        @(negedge sys_clk);
        {sfr_wr, sfr_rd, sfr_bit_wr} = 3'b000;
        @(negedge sys_clk);
    endtask
    task automatic cmp(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic chk(input logic [7:0] a, input logic [7:0] exp);
        op(1, a, 8'h00);
        cmp($sformatf("register %h", a), sfr_rdata, exp);
    endtask
    // Run bit s is set for exactly k machine cycles, so exactly k counts land.
    task automatic run_for(input logic [2:0] s, input logic [7:0] k);
        op(2, 8'h88, {5'h01, s});
        repeat (12 * k - 2) @(negedge sys_clk);
        op(2, 8'h88, {5'h00, s});
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        {sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, vector_ack_zero, vector_ack_one} = 6'h00;
        {sfr_addr, sfr_wdata, sfr_bit_sel} = 19'h0_0000;
        err_count = 0;
        n_compared = 0;
        sys_rst = 1'b1;
        repeat (4) @(negedge sys_clk);
        sys_rst = 1'b0;
        chk(8'h88, 8'h00);
        chk(8'h8E, 8'h00);
        chk(8'h89, 8'h00);
        op(2, 8'h89, 8'h0F);
        chk(8'h89, 8'h00);
        op(0, 8'h89, 8'hA5);
        chk(8'h89, 8'hA5);
        op(2, 8'h88, 8'h0C);
        chk(8'h88, 8'h10);
        op(2, 8'h88, 8'h04);
        $display("test registers done");
        foreach (TAB[i]) begin
            r = TAB[i];
            op(0, 8'h89, r[71:64]);
            op(0, r[63:56], r[55:48]);
            op(0, r[63:56] + 8'h02, r[47:40]);
            u_tcz_pins_model.gates(r[37:36]);
            run_for(r[34:32], r[31:24]);
            chk(r[63:56], r[23:16]);
            chk(r[63:56] + 8'h02, r[15:8]);
            chk(8'h88, r[7:0]);
            cmp("flags", {overflow_flag_counter_one, 1'b0, overflow_flag_counter_zero, 5'h00}, r[7:0]);
            {vector_ack_one, vector_ack_zero} = 2'b11;
            @(negedge sys_clk);
            {vector_ack_one, vector_ack_zero} = 2'b00;
            $display("test mode row %0d done", i);
        end
        op(0, 8'h89, 8'h50);
        op(0, 8'h8B, 8'h00);
        op(2, 8'h88, 8'h0E);
        u_tcz_pins_model.pulses(3);
        repeat (24) @(negedge sys_clk);
        op(2, 8'h88, 8'h06);
        chk(8'h8B, 8'h03);
        $display("test event counting done");
        summarize();
    end
endmodule
`default_nettype wire
